// ==== rtcw_checker.sv ====
// Purpose: Assertions on the two-wire link and timekeeping.
// Assumes: Bus levels are resolved inside rtcw_if.
// Notes:   Instantiated beside the interface in the bench.
`timescale 1ns/10ps
module rtcw_checker (
    input wire logic       linkClk,   // Link clock
    input wire logic       ref_clk,   // Reference clock
    input wire logic       resetn,    // Async reset, active low
    input wire logic       scl,       // Resolved SCL
    input wire logic       sda,       // Resolved SDA
    input wire logic       devSdaOe,  // Device pulls SDA
    input wire logic       tick1Hz,   // Second tick in
    input wire logic       secTick,   // Second tick out
    input wire logic       frozen     // Time counting held
);
    // ****
    // Watchdog tick count
    // ****
    logic [1:0] wdTicks_q;
    // Cleared when thawed, so a stale count cannot fire early
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            wdTicks_q <= 2'h0;
        else
            wdTicks_q <= frozen ? wdTicks_q + {1'b0, tick1Hz} : 2'h0;
    end

    chk_pull_low: assert property (
        @(posedge linkClk) disable iff (!resetn)
        scl && $past(scl) && !$past(devSdaOe) |-> !devSdaOe)
        else $error("device pulled SDA while SCL high");
    chk_ack_hold: assert property (
        @(posedge linkClk) disable iff (!resetn)
        $rose(scl) && devSdaOe |-> devSdaOe [*8])
        else $error("device low not held over SCL high");
    chk_tick_pass: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        tick1Hz && !frozen |=> secTick)
        else $error("tick lost while running");
    chk_tick_lost: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        tick1Hz && frozen && wdTicks_q == 2'h0 |=> !secTick)
        else $error("tick passed while frozen");
    chk_wd_pass: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        tick1Hz && frozen && wdTicks_q == 2'h1 |=> secTick && !frozen)
        else $error("expiry tick not passed");
    chk_tick_cause: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        secTick |-> $past(tick1Hz))
        else $error("tick out without tick in");
    chk_wd_late: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        frozen |-> wdTicks_q < 2'h2)
        else $error("watchdog late");
    chk_wd_early: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        frozen && tick1Hz && wdTicks_q == 2'h0 |=> frozen)
        else $error("watchdog early");
    chk_stop_thaw: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        scl && $rose(sda) |-> ##[0:8] !frozen)
        else $error("freeze kept after stop");
endmodule

// ==== rtcw_dev_end.sv ====
// Purpose: RTC two-wire slave with time freeze and interface watchdog.
// Assumes: linkClk oversamples SCL; tick1Hz is a one-cycle ref_clk pulse.
// Notes:   Register storage is a 16-byte shadow; writes are reported out.
//
// How it works
// - Sender holds SDA steady while SCL high
// - SDA change during SCL high is control
// - Master starts only on idle bus
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Eight bits plus acknowledge, unlimited bytes
// - Master adds ack pulse, sender releases SDA
// - Addressed slave acknowledges every received byte
// - Master acknowledges read bytes except last
// - Acknowledger holds SDA low through ack pulse
// - Master ends read by withholding ack
// - On master NACK the device releases SDA
// - First byte is address; respond on match
// - Slave only: SCL input, SDA open drain
// - Only low four word address bits used
// - Time counting frozen during an access
// - Abort access after one second stall
// - START or STOP stops the watchdog
// - Watchdog fires between one and two seconds
// - Each expiry drops exactly one second tick
`timescale 1ns/10ps
module rtcw_dev_end (
    input  wire logic       linkClk,  // Bus sampling clock
    input  wire logic       ref_clk,  // Timekeeping clock
    input  wire logic       resetn,   // Async reset, active low
    rtcw_if.dev             bus,      // Two-wire bus
    input  wire logic       tick1Hz,  // Prescaler second tick (pulse)
    output logic            secTick,  // Tick passed to time counters
    output logic            frozen,   // Time counting held
    output logic            wrStb,    // Register written (pulse)
    output logic [3:0]      wrAddr,   // Written register index
    output logic [7:0]      wrData    // Written register value
);
    import rtcw_pkg::*;

    // ****************************************************************
    // State of both clock domains
    // ****************************************************************
    typedef struct packed {
        logic             sclS1;
        logic             sclS2;
        logic             sclP;
        logic             sdaS1;
        logic             sdaS2;
        logic             sdaP;
        logic             sclHi;
        rtcw_dst_t        st;
        logic [3:0]       bitCnt;
        logic [7:0]       shift;
        logic [3:0]       ptr;
        logic             rdMode;
        logic             mAck;
        logic             sdaLow;
        logic [15:0][7:0] mem;
        logic             active;
        logic             wrTgl;
        logic [3:0]       wrA;
        logic [7:0]       wrD;
        logic             ab1;
        logic             ab2;
        logic             ab3;
    } rtcw_lreg_t;

    typedef struct packed {
        logic       a1;
        logic       a2;
        logic       w1;
        logic       w2;
        logic       w3;
        logic [1:0] wdCnt;
        logic       wdFired;
        logic       abortTgl;
        logic       secTick;
        logic       frozen;
        logic       wrStb;
        logic [3:0] wrAddr;
        logic [7:0] wrData;
    } rtcw_rreg_t;

    rtcw_lreg_t lq, ld;
    rtcw_rreg_t rq, rd;
    logic       sclRise;
    logic       sclFall;
    logic       startC;
    logic       stopC;
    logic       abortEv;

    // Load the next byte for the master and advance the pointer
    function automatic rtcw_lreg_t loadTx(input rtcw_lreg_t s);
        rtcw_lreg_t r;
        r = s;
        r.shift = s.mem[s.ptr];
        r.sdaLow = !s.mem[s.ptr][7];
        r.ptr = s.ptr + 4'h1;
        return r;
    endfunction

    // ****************************************************************
    // Link domain: bit and byte handling
    // ****************************************************************
    // Edges are taken only from the second sync stage onward
    always_comb begin
        ld = lq;
        ld.sclS1 = bus.scl;
        ld.sclS2 = lq.sclS1;
        ld.sclP  = lq.sclS2;
        ld.sdaS1 = bus.sda;
        ld.sdaS2 = lq.sdaS1;
        ld.sdaP  = lq.sdaS2;
        ld.ab1 = rq.abortTgl;
        ld.ab2 = lq.ab1;
        ld.ab3 = lq.ab2;
        sclRise = lq.sclS2 && !lq.sclP;
        sclFall = !lq.sclS2 && lq.sclP;
        startC = lq.sclS2 && lq.sclP && lq.sdaP && !lq.sdaS2;
        stopC  = lq.sclS2 && lq.sclP && !lq.sdaP && lq.sdaS2;
        abortEv = lq.ab2 ^ lq.ab3;
        if (abortEv) begin
            // Watchdog clears the interface and releases the line
            ld.st = DS_IDLE;
            ld.sdaLow = 1'b0;
            ld.active = 1'b0;
        end else if (startC) begin
            ld.st = DS_ADDR;
            ld.bitCnt = 4'h0;
            ld.sclHi = 1'b0;
            ld.sdaLow = 1'b0;
            ld.active = 1'b0;
        end else if (stopC) begin
            ld.st = DS_IDLE;
            ld.sdaLow = 1'b0;
            ld.active = 1'b0;
        end else if (lq.st != DS_IDLE) begin
            // A fall counts only after a rise, so the fall ending START
            // is not taken for the end of a bit
            if (sclRise) ld.sclHi = 1'b1;
            // Sample on rise; master holds SDA while SCL high
            if (sclRise && lq.bitCnt != RTCW_ACK_BIT) begin
                if (lq.st != DS_READ) ld.shift = {lq.shift[6:0], lq.sdaS2};
            end
            if (sclRise && lq.bitCnt == RTCW_ACK_BIT) begin
                ld.mAck = !lq.sdaS2;
            end
            if (sclFall && lq.sclHi) begin
                ld.sclHi = 1'b0;
                if (lq.bitCnt == RTCW_LAST_BIT) begin
                    ld.bitCnt = RTCW_ACK_BIT;
                    unique case (lq.st)
                        DS_ADDR: begin
                            if (lq.shift[7:1] == RTCW_SLAVE_ADDR) begin
                                ld.sdaLow = 1'b1;
                                ld.active = 1'b1;
                                ld.rdMode = lq.shift[0];
                            end else begin
                                ld.st = DS_IDLE;
                            end
                        end
                        DS_WORD: begin
                            ld.ptr = lq.shift[3:0];
                            ld.sdaLow = 1'b1;
                        end
                        DS_WRITE: begin
                            ld.mem[lq.ptr] = lq.shift;
                            ld.ptr = lq.ptr + 4'h1;
                            ld.wrTgl = !lq.wrTgl;
                            ld.wrA = lq.ptr;
                            ld.wrD = lq.shift;
                            ld.sdaLow = 1'b1;
                        end
                        default: begin
                            ld.sdaLow = 1'b0;
                        end
                    endcase
                end else if (lq.bitCnt == RTCW_ACK_BIT) begin
                    ld.bitCnt = 4'h0;
                    ld.sdaLow = 1'b0;
                    unique case (lq.st)
                        DS_ADDR: begin
                            if (lq.rdMode) begin
                                ld = loadTx(ld);
                                ld.st = DS_READ;
                            end else begin
                                ld.st = DS_WORD;
                            end
                        end
                        DS_WORD:  ld.st = DS_WRITE;
                        DS_WRITE: ld.st = DS_WRITE;
                        default: begin
                            // No ack from master: stay off the line
                            if (lq.mAck) begin
                                ld = loadTx(ld);
                            end else begin
                                ld.st = DS_IDLE;
                            end
                        end
                    endcase
                end else begin
                    ld.bitCnt = lq.bitCnt + 4'h1;
                    if (lq.st == DS_READ) begin
                        ld.shift = {lq.shift[6:0], 1'b0};
                        ld.sdaLow = !lq.shift[6];
                    end
                end
            end
        end
    end

    // Link domain register
    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            lq <= '{st: DS_IDLE, sclS1: 1'b1, sclS2: 1'b1, sclP: 1'b1,
                    sdaS1: 1'b1, sdaS2: 1'b1, sdaP: 1'b1,
                    ptr: RTCW_PTR_RST, default: '0};
        end else begin
            lq <= ld;
        end
    end

    // ****************************************************************
    // Reference domain: freeze, watchdog and write reports
    // ****************************************************************
    // Counting 1 Hz ticks bounds the timeout without a 25M-cycle counter
    always_comb begin
        rd = rq;
        rd.a1 = lq.active;
        rd.a2 = rq.a1;
        rd.w1 = lq.wrTgl;
        rd.w2 = rq.w1;
        rd.w3 = rq.w2;
        rd.wrStb = rq.w2 ^ rq.w3;
        if (rq.w2 ^ rq.w3) begin
            // Held words are stable for a full byte after the toggle
            rd.wrAddr = lq.wrA;
            rd.wrData = lq.wrD;
        end
        if (!rq.a2) begin
            rd.wdCnt = 2'h0;
            rd.wdFired = 1'b0;
        end else if (tick1Hz && rq.frozen) begin
            if (rq.wdCnt == RTCW_WD_TICKS - 2'h1) begin
                rd.wdFired = 1'b1;
                rd.abortTgl = !rq.abortTgl;
            end else begin
                rd.wdCnt = rq.wdCnt + 2'h1;
            end
        end
        rd.frozen = rq.a2 && !rd.wdFired;
        // First frozen tick is dropped, the expiry tick goes through,
        // so a stalled access costs exactly one second
        rd.secTick = tick1Hz && (!rq.frozen || rd.wdFired);
    end

    // Reference domain register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rq <= '0;
        end else begin
            rq <= rd;
        end
    end

    assign bus.devSdaOut = 1'b0;
    assign bus.devSdaOe  = lq.sdaLow;
    assign secTick = rq.secTick;
    assign frozen  = rq.frozen;
    assign wrStb   = rq.wrStb;
    assign wrAddr  = rq.wrAddr;
    assign wrData  = rq.wrData;
endmodule

// ==== rtcw_host_end.sv ====
// Purpose: Two-wire master that writes or reads one device register.
// Assumes: No clock stretching by the device; one request at a time.
// Notes:   SCL is divided from ref_clk; reads end with a NACK and STOP.
`timescale 1ns/10ps
module rtcw_host_end (
    input  wire logic       ref_clk,  // 25 MHz system clock
    input  wire logic       resetn,   // Async reset, active low
    rtcw_if.host            bus,      // Two-wire bus
    input  wire logic       reqGo,    // Start a request (pulse)
    input  wire logic       reqRead,  // 1 read, 0 write
    input  wire logic [3:0] reqReg,   // Register word address
    input  wire logic [7:0] reqData,  // Write data
    output logic            busy,     // Request in progress
    output logic            done,     // Request finished (pulse)
    output logic [7:0]      rdData,   // Byte read back
    output logic            nack      // Device withheld an acknowledge
);
    import rtcw_pkg::*;

    typedef struct packed {
        rtcw_hst_t  st;
        logic [4:0] qc;
        logic [1:0] ph;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [2:0] step;
        logic       rd;
        logic [3:0] reg4;
        logic [7:0] wdat;
        logic       sclLow;
        logic       sdaLow;
        logic       sclS1;
        logic       sclS2;
        logic       sdaS1;
        logic       sdaS2;
        logic       busy;
        logic       done;
        logic [7:0] rdData;
        logic       nack;
    } rtcw_hreg_t;

    rtcw_hreg_t q, d;
    logic       tick;
    logic       rx;

    // ****************************************************************
    // Bit sequencer
    // ****************************************************************
    // Each bit takes four quarter periods; SDA moves only while SCL low
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.sclS1 = bus.scl;
        d.sclS2 = q.sclS1;
        d.sdaS1 = bus.sda;
        d.sdaS2 = q.sdaS1;
        tick = (q.qc == RTCW_QTR_CYC - 5'h01);
        rx = (q.step == 3'h4);
        if (q.st != HS_IDLE) begin
            d.qc = tick ? 5'h00 : q.qc + 5'h01;
        end
        unique case (q.st)
            HS_IDLE: begin
                // Begin only on an idle bus, both lines high
                if (reqGo && q.sclS2 && q.sdaS2) begin
                    d.st = HS_START;
                    d.busy = 1'b1;
                    d.nack = 1'b0;
                    d.rd = reqRead;
                    d.reg4 = reqReg;
                    d.wdat = reqData;
                    d.step = 3'h0;
                    d.ph = 2'h0;
                    d.qc = 5'h00;
                    d.shift = {RTCW_SLAVE_ADDR, 1'b0};
                end
            end
            HS_START: if (tick) begin
                d.ph = q.ph + 2'h1;
                if (q.ph == 2'h0) d.sdaLow = 1'b1;
                if (q.ph == 2'h1) d.sclLow = 1'b1;
                if (q.ph == 2'h2) begin
                    d.st = HS_BYTE;
                    d.ph = 2'h0;
                    d.bitCnt = 4'h0;
                end
            end
            HS_RSTART: if (tick) begin
                d.ph = q.ph + 2'h1;
                if (q.ph == 2'h0) d.sdaLow = 1'b0;
                if (q.ph == 2'h1) d.sclLow = 1'b0;
                if (q.ph == 2'h2) d.sdaLow = 1'b1;
                if (q.ph == 2'h3) begin
                    d.sclLow = 1'b1;
                    d.st = HS_BYTE;
                    d.bitCnt = 4'h0;
                    d.step = 3'h3;
                    d.shift = {RTCW_SLAVE_ADDR, 1'b1};
                end
            end
            HS_BYTE: if (tick) begin
                d.ph = q.ph + 2'h1;
                if (q.ph == 2'h0) begin
                    // Ack slot is released; a read takes one byte, so NACK
                    if (q.bitCnt == RTCW_ACK_BIT || rx) begin
                        d.sdaLow = 1'b0;
                    end else begin
                        d.sdaLow = !q.shift[7];
                    end
                end
                if (q.ph == 2'h1) d.sclLow = 1'b0;
                if (q.ph == 2'h2) begin
                    if (q.bitCnt != RTCW_ACK_BIT && rx) begin
                        d.shift = {q.shift[6:0], q.sdaS2};
                    end
                    if (q.bitCnt == RTCW_ACK_BIT && !rx && q.sdaS2) begin
                        d.nack = 1'b1;
                    end
                end
                if (q.ph == 2'h3) begin
                    d.sclLow = 1'b1;
                    d.bitCnt = q.bitCnt + 4'h1;
                    if (q.bitCnt != RTCW_ACK_BIT && !rx) begin
                        d.shift = {q.shift[6:0], 1'b0};
                    end
                    if (q.bitCnt == RTCW_ACK_BIT) begin
                        d.bitCnt = 4'h0;
                        if (q.nack || q.step == 3'h2) begin
                            d.st = HS_STOP;
                        end else if (q.step == 3'h0) begin
                            d.step = 3'h1;
                            d.shift = {RTCW_WORD_HI, q.reg4};
                        end else if (q.step == 3'h1) begin
                            d.step = 3'h2;
                            d.shift = q.wdat;
                            if (q.rd) d.st = HS_RSTART;
                        end else if (q.step == 3'h3) begin
                            d.step = 3'h4;
                            d.shift = RTCW_BYTE_RST;
                        end else begin
                            d.rdData = q.shift;
                            d.st = HS_STOP;
                        end
                    end
                end
            end
            HS_STOP: if (tick) begin
                d.ph = q.ph + 2'h1;
                if (q.ph == 2'h0) d.sdaLow = 1'b1;
                if (q.ph == 2'h1) d.sclLow = 1'b0;
                if (q.ph == 2'h2) d.sdaLow = 1'b0;
                if (q.ph == 2'h3) begin
                    d.st = HS_IDLE;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{st: HS_IDLE, sclS1: 1'b1, sclS2: 1'b1, sdaS1: 1'b1,
                   sdaS2: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign bus.hostSclOut = 1'b0;
    assign bus.hostSdaOut = 1'b0;
    assign bus.hostSclOe  = q.sclLow;
    assign bus.hostSdaOe  = q.sdaLow;
    assign busy   = q.busy;
    assign done   = q.done;
    assign rdData = q.rdData;
    assign nack   = q.nack;
endmodule

// ==== rtcw_if.sv ====
// Purpose: Two-wire bus between the host end and the device end.
// Assumes: Both lines are open drain with pull-ups.
// Notes:   The wired-AND level is resolved here from the enables.
`timescale 1ns/10ps
interface rtcw_if;
    logic hostSclOut;   // Host SCL drive value, always low
    logic hostSclOe;    // Host pulls SCL low
    logic hostSdaOut;   // Host SDA drive value, always low
    logic hostSdaOe;    // Host pulls SDA low
    logic devSdaOut;    // Device SDA drive value, always low
    logic devSdaOe;     // Device pulls SDA low
    logic scl;          // Resolved SCL level
    logic sda;          // Resolved SDA level

    // Pull-up wins unless some party enables a low drive
    assign scl = !(hostSclOe && !hostSclOut);
    assign sda = !(hostSdaOe && !hostSdaOut) && !(devSdaOe && !devSdaOut);

    modport host (output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe,
                  input  scl, sda);
    modport dev  (output devSdaOut, devSdaOe, input scl, sda);
endinterface

// ==== rtcw_pkg.sv ====
// Purpose: Shared constants and state codes for the RTC two-wire link.
// Assumes: Host runs on a 25 MHz ref_clk; device samples on its link clock.
// Notes:   Both ends and the bench import this package.
package rtcw_pkg;

    // ****************************************************************
    // Addressing and byte framing
    // ****************************************************************
    // Address value is arbitrary; override to match the target bus
    localparam logic [6:0] RTCW_SLAVE_ADDR = 7'h51;
    localparam logic [3:0] RTCW_LAST_BIT   = 4'h7;  // Eighth data bit
    localparam logic [3:0] RTCW_ACK_BIT    = 4'h8;  // Ninth clock pulse
    localparam logic [3:0] RTCW_PTR_RST    = 4'h0;  // Word pointer reset
    localparam logic [7:0] RTCW_BYTE_RST   = 8'h00;
    localparam logic [3:0] RTCW_WORD_HI    = 4'h0;  // Unused word bits

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int         RTCW_REF_HZ     = 25_000_000;
    localparam int         RTCW_SCL_HZ     = 400_000;
    // Quarter bit period rounded up, so SCL never beats its rate
    localparam logic [4:0] RTCW_QTR_CYC    =
        5'((RTCW_REF_HZ + 4 * RTCW_SCL_HZ - 1) / (4 * RTCW_SCL_HZ));
    localparam int         RTCW_WD_MIN_S   = 1;     // Watchdog earliest
    localparam int         RTCW_WD_MAX_S   = 2;     // Watchdog latest
    // Second 1 Hz tick after the address lands between the two limits
    localparam logic [1:0] RTCW_WD_TICKS   = 2'(RTCW_WD_MAX_S);

    // ****************************************************************
    // State codes
    // ****************************************************************
    typedef enum logic [2:0] {
        DS_IDLE  = 3'h0,
        DS_ADDR  = 3'h1,
        DS_WORD  = 3'h2,
        DS_WRITE = 3'h3,
        DS_READ  = 3'h4
    } rtcw_dst_t;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'h0,
        HS_START  = 3'h1,
        HS_BYTE   = 3'h2,
        HS_RSTART = 3'h3,
        HS_STOP   = 3'h4
    } rtcw_hst_t;

endpackage

// ==== rtcw_tb_top.sv ====
// Purpose: Host end against device end, self-checking.
// Assumes: Shadow registers read back what was written.
// Notes:   Ticks are pulsed fast to reach the watchdog.
`timescale 1ns/10ps
module rtcw_tb_top;
    import rtcw_pkg::*;
    logic        ref_clk = 1'b0;
    logic        linkClk = 1'b0;
    logic        resetn  = 1'b0;
    logic        reqGo   = 1'b0;
    logic        reqRead = 1'b0;
    logic        tick1Hz = 1'b0;
    logic [3:0]  reqReg  = 4'h0;
    logic [7:0]  reqData = 8'h00;
    logic [3:0]  wrAddr;
    logic [7:0]  rdData, wrData;
    logic        busy, done, nack, secTick, frozen, wrStb;
    logic [11:0] hq[$], wq[$], e;
    logic [3:0]  rg[4];
    logic [7:0]  dt[4];
    int          mismatches = 0, n_compared = 0, cyc = 0, seed = 32'h184A;

    rtcw_if bus ();
    always #20 ref_clk = !ref_clk;
    // Rising edges of the two clocks never coincide
    always #3 linkClk = !linkClk;

    rtcw_host_end i_rtcw_host_end (.ref_clk, .resetn, .bus(bus.host),
        .reqGo, .reqRead, .reqReg, .reqData, .busy, .done, .rdData, .nack);
    rtcw_dev_end i_rtcw_dev_end (.linkClk, .ref_clk, .resetn,
        .bus(bus.dev), .tick1Hz, .secTick, .frozen, .wrStb, .wrAddr,
        .wrData);
    rtcw_checker i_rtcw_checker (.linkClk, .ref_clk, .resetn,
        .scl(bus.scl), .sda(bus.sda), .devSdaOe(bus.devSdaOe), .tick1Hz,
        .secTick, .frozen);

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One request; a second go while busy must be ignored
    task automatic req(input logic rd, input logic [3:0] r,
        input logic [7:0] d, input logic nk, input int t1, input int t2);
        int k;
        hq.push_back({2'h0, rd, nk, rd ? d : 8'h00});
        if (!rd && !nk)
            wq.push_back({r, d});
        @(negedge ref_clk);
        reqGo = 1'b1;
        reqRead = rd;
        reqReg = r;
        reqData = d;
        for (k = 0; k < 9000 && done !== 1'b1; k++) begin
            @(negedge ref_clk);
            reqGo = (k == 50);
            tick1Hz = (k == t1 || k == t2);
        end
        reqGo = 1'b0;
        tick1Hz = 1'b0;
        check({10'h0, busy, done}, 12'h001);
    endtask

    // Watchers sample away from the launching edge, oldest note first
    always @(negedge ref_clk) begin
        if (done === 1'b1) begin
            e = hq.size() ? hq.pop_front() : 12'hFFF;
            check({2'h0, e[9], nack, e[9] ? rdData : 8'h00}, e);
        end
        if (wrStb === 1'b1) begin
            e = wq.size() ? wq.pop_front() : 12'hFFF;
            check({wrAddr, wrData}, e);
        end
    end

    // Hang guard sized well above ten transfers
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            stop_test;
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) begin
            @(negedge ref_clk);
            tick1Hz = ~tick1Hz;
        end
        $display("test idle ticks done");
        for (int i = 0; i < 4; i++) begin
            rg[i] = {1'b0, 2'(i), 1'($random(seed))};
            dt[i] = 8'($random(seed));
            req(1'b0, rg[i], dt[i], 1'b0, 800, -1);
        end
        $display("test writes done");
        for (int i = 0; i < 4; i++)
            req(1'b1, rg[i], dt[i], 1'b0, 800, -1);
        $display("test reads done");
        // Two ticks while frozen abort the write during the word byte
        req(1'b0, 4'hB, 8'hA5, 1'b1, 800, 810);
        req(1'b1, 4'hB, 8'h00, 1'b0, -1, -1);
        $display("test watchdog done");
        stop_test;
    end
endmodule
